// ### hdl/level_switch_defines.svh
`ifndef LEVEL_SWITCH_DEFINES_SVH
`define LEVEL_SWITCH_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL      12'h000
`define OFS_CAL       12'h004
`define OFS_SWPT      12'h008
`define OFS_SIM       12'h00C
`define OFS_SIMVAL    12'h010
`define OFS_RAMP      12'h014
`define OFS_OUTMAN    12'h018
`define OFS_CMD       12'h01C
`define OFS_STATUS    12'h020
`define OFS_SENSPK    12'h024
`define OFS_TEMPPK    12'h028
`define OFS_HOURS     12'h02C
`define OFS_ADDR      12'h030
`define OFS_SAFE      12'h034

// ----------------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------------
`define CMD_FACTORY   0
`define CMD_WARM      1
`define CMD_ADDR      2
`define CMD_PK_SENS   3
`define CMD_PK_TEMP   4
`define CMD_STEST     5

`define ST_SUBST      8'h4B
`define ST_LASTUSE    8'h47
`define ST_UNCERT_INI 8'h4C
`define ST_GOOD       8'h80
`define ADDR_DEFAULT  7'h7E

`define DISP_NONE     16'h2020
`define DISP_L        16'h4C20
`define DISP_LC       16'h4C63
`define DISP_LA       16'h4C41
`define DISP_LL       16'h4C4C
`define DISP_SI       16'h5349

// ----------------------------------------------------------------------
// timing, 50 MHz clock
// ----------------------------------------------------------------------
`define CLK_HZ        50000000
`define COLD_FLAG_S   10
`define WARM_FLAG_S   3
`define COMM_LOSS_S   30
`define HOUR_S        3600
`define CYC_PER_S     (`CLK_HZ)
`define CYC_PER_MS    (`CLK_HZ / 1000)

`endif

// ### hdl/level_switch_fault_sim_lock.sv
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "level_switch_defines.svh"

module level_switch_fault_sim_lock
	import level_switch_pkg::*;
#(
	parameter int unsigned COLD_CYC = `COLD_FLAG_S * `CYC_PER_S,
	parameter int unsigned WARM_CYC = `WARM_FLAG_S * `CYC_PER_S,
	parameter int unsigned LOSS_CYC = `COMM_LOSS_S * `CYC_PER_S,
	// an hour of 50 MHz cycles does not fit in 32 bits
	parameter longint unsigned HOUR_CYC = 64'(`HOUR_S) * `CYC_PER_S,
	parameter int unsigned MS_CYC   = `CYC_PER_MS
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// measurement stage
	input  wire logic        sample_valid,
	input  wire logic [15:0] sensor_counts,
	input  wire logic [15:0] elec_temp,
	input  wire logic        sensor_quality_bad,
	input  wire logic [7:0]  sensor_status,
	input  wire logic        stest_pass,
	// bus link condition and keypad, asynchronous
	input  wire logic        bus_alive,
	input  wire logic        key_edit_req,
	input  wire logic        key_guard_toggle,
	// cyclic output and display
	output logic             out_level,
	output logic [7:0]       out_status,
	output logic [15:0]      disp_mode,
	output logic [15:0]      disp_lock,
	output logic             disp_update_alert,
	output logic             bus_drop,
	output logic [6:0]       station_addr
);
	import level_switch_pkg::*;

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic       key_guard_d;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
			key_guard_d <= 1'b0;
		end else begin
			sync1 <= {bus_alive, key_edit_req, key_guard_toggle};
			sync2 <= sync1;
			key_guard_d <= sync2[0];
		end
	end
	wire alive_s     = sync2[2];
	wire key_edit_s  = sync2[1];
	wire key_guard_p = sync2[0] & ~key_guard_d;

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	logic [31:0] ctrl;   // [0] bus lock [1] keypad enable [2] invert [4:3] fallback
	logic [31:0] cal;    // [15:0] zero counts [31:16] full counts
	logic [31:0] swpt;   // [7:0] on percent [15:8] off percent
	logic [31:0] sim;    // [0] hand [1] in sim [2] sens fix [3] sens ramp [4] temp sim
	logic [31:0] simval; // [15:0] sensor/temp [16] input level [31:24] input status
	logic [31:0] ramp;   // [15:0] end [31:16] dwell ms
	logic [31:0] outman; // [0] value [15:8] status
	logic [31:0] safe;   // [0] safety value
	logic        hw_guard;
	logic [6:0]  addr;
	logic        key_saved;
	logic        comm_lost;

	// apb decode, zero-wait
	wire acc = psel & penable;
	wire wr  = acc & pwrite;
	wire mapped = (paddr[1:0] == 2'h0) && (paddr <= `OFS_SAFE);
	wire bus_ok = ~hw_guard & ~ctrl[0];
	wire wr_ok  = wr & mapped & bus_ok;
	wire wr_cmd = wr & (paddr == `OFS_CMD);
	wire cmd_ok = wr_cmd & bus_ok;
	wire factory = cmd_ok & pwdata[`CMD_FACTORY];
	wire key_ok  = key_edit_s & ~hw_guard & (ctrl[1] | comm_lost);
	assign pready  = 1'b1;
	assign pslverr = acc & (~mapped | (pwrite & ~bus_ok));

	// register writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= 32'h2; cal <= 32'hFFFF_0000; swpt <= 32'h2832;
			sim <= 32'h0; simval <= 32'h0; ramp <= 32'h0;
			outman <= 32'h0; safe <= 32'h0; hw_guard <= 1'b0;
		end else if (factory) begin
			ctrl <= 32'h2; cal <= 32'hFFFF_0000; swpt <= 32'h2832;
			sim <= 32'h0; simval <= 32'h0; ramp <= 32'h0;
			outman <= 32'h0; safe <= 32'h0;
		end else begin
			if (wr_ok && paddr == `OFS_CTRL) ctrl <= pwdata;
			if (wr_ok && paddr == `OFS_CAL) cal <= pwdata;
			if (wr_ok && paddr == `OFS_SWPT) swpt <= pwdata;
			if (wr_ok && paddr == `OFS_SIM) sim <= pwdata;
			if (wr_ok && paddr == `OFS_SIMVAL) simval <= pwdata;
			if (wr_ok && paddr == `OFS_RAMP) ramp <= pwdata;
			if (wr_ok && paddr == `OFS_OUTMAN) outman <= pwdata;
			if (wr_ok && paddr == `OFS_SAFE) safe <= pwdata;
			if (key_guard_p) hw_guard <= ~hw_guard;
			// forced on while the bus is lost
			if (comm_lost && alive_s) ctrl[1] <= key_saved;
			else if (comm_lost) ctrl[1] <= 1'b1;
			if (key_ok) ctrl[2] <= ~ctrl[2]; // local edit: inversion
		end
	end

	// ------------------------------------------------------------------
	// bus loss supervision
	// ------------------------------------------------------------------
	logic [31:0] loss_cnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			loss_cnt <= 32'h0; comm_lost <= 1'b0; key_saved <= 1'b1;
		end else if (alive_s) begin
			loss_cnt <= 32'h0; comm_lost <= 1'b0;
		end else if (!comm_lost) begin
			if (loss_cnt >= LOSS_CYC - 1) begin
				comm_lost <= 1'b1; key_saved <= ctrl[1];
			end else loss_cnt <= loss_cnt + 32'h1;
		end
	end

	// ------------------------------------------------------------------
	// commands: address, flags, warm start
	// ------------------------------------------------------------------
	logic [31:0] cold_cnt;
	logic [31:0] warm_cnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr <= `ADDR_DEFAULT; cold_cnt <= 32'h0; warm_cnt <= 32'h0;
		end else begin
			if (cmd_ok && pwdata[`CMD_ADDR]) addr <= `ADDR_DEFAULT;
			else if (wr_ok && paddr == `OFS_ADDR) addr <= pwdata[6:0];
			if (factory) cold_cnt <= COLD_CYC;
			else if (cold_cnt != 32'h0) cold_cnt <= cold_cnt - 32'h1;
			if (cmd_ok && pwdata[`CMD_WARM]) warm_cnt <= WARM_CYC;
			else if (warm_cnt != 32'h0) warm_cnt <= warm_cnt - 32'h1;
		end
	end
	wire cold_flag = cold_cnt != 32'h0;
	wire warm_flag = warm_cnt != 32'h0;
	assign station_addr = addr;
	assign disp_update_alert = cold_flag;
	assign bus_drop = warm_flag;

	// ------------------------------------------------------------------
	// ramp simulation
	// ------------------------------------------------------------------
	logic [15:0] ramp_val;
	logic        ramp_up;
	logic [31:0] dwell;
	logic [15:0] ms_cnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ramp_val <= 16'h0; ramp_up <= 1'b1; dwell <= 32'h0; ms_cnt <= 16'h0;
		end else if (!sim[3]) begin
			ramp_val <= simval[15:0]; ramp_up <= 1'b1; dwell <= 32'h0;
		end else if (dwell >= {16'h0, ramp[31:16]} * MS_CYC) begin
			dwell <= 32'h0;
			if (ramp_up) begin
				if (ramp_val >= ramp[15:0]) ramp_up <= 1'b0;
				else ramp_val <= ramp_val + 16'h1;
			end else begin
				if (ramp_val <= simval[15:0]) ramp_up <= 1'b1;
				else ramp_val <= ramp_val - 16'h1;
			end
		end else dwell <= dwell + 32'h1;
	end

	// ------------------------------------------------------------------
	// measurement path
	// ------------------------------------------------------------------
	wire [15:0] sens_v = sim[3] ? ramp_val : (sim[2] ? simval[15:0] : sensor_counts);
	wire [15:0] temp_v = sim[4] ? simval[15:0] : elec_temp;
	wire [15:0] span = cal[31:16] - cal[15:0];
	wire [15:0] off  = (sens_v > cal[15:0]) ? sens_v - cal[15:0] : 16'h0;
	wire [31:0] prod = {16'h0, off} * 32'd100;
	wire [31:0] pct32 = (span == 16'h0) ? 32'h0 : prod / {16'h0, span};
	wire [7:0]  pct = (pct32 > 32'd100) ? 8'd100 : pct32[7:0];

	logic        sw_state;
	logic        level;
	logic [31:0] dly_cnt;
	logic        seen;
	logic        last_good;
	logic [15:0] smin, smax, tmin, tmax;
	logic [31:0] hours;
	logic [63:0] hour_tick;
	wire       pre_level = sim[1] ? simval[16] : level;
	wire [7:0] meas_stat = sensor_quality_bad ? sensor_status : `ST_GOOD;
	wire [7:0] pre_stat  = sim[1] ? simval[31:24] : meas_stat;
	wire       pre_bad   = pre_stat[7:6] == 2'h0;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sw_state <= 1'b0; level <= 1'b0; dly_cnt <= 32'h0; seen <= 1'b0;
			last_good <= 1'b0;
			smin <= 16'hFFFF; smax <= 16'h0; tmin <= 16'hFFFF; tmax <= 16'h0;
			hours <= 32'h0; hour_tick <= 64'h0;
		end else begin
			if (sample_valid) begin
				if (pct >= swpt[7:0]) sw_state <= 1'b1;
				else if (pct <= swpt[15:8]) sw_state <= 1'b0;
			end
			// a warm start forgets the last measurement
			if (cmd_ok && pwdata[`CMD_WARM]) seen <= 1'b0;
			else if (sample_valid) seen <= 1'b1;
			// tracked every cycle, since the level lags the sample by the delay
			if (!pre_bad) last_good <= pre_level;
			if (sw_state == level) dly_cnt <= 32'h0;
			else if (dly_cnt >= {16'h0, ramp[31:16]}) level <= sw_state;
			else dly_cnt <= dly_cnt + 32'h1;
			if (cmd_ok && pwdata[`CMD_PK_SENS]) begin
				smin <= sens_v; smax <= sens_v;
			end else if (sample_valid) begin
				if (sens_v < smin) smin <= sens_v;
				if (sens_v > smax) smax <= sens_v;
			end
			if (cmd_ok && pwdata[`CMD_PK_TEMP]) begin
				tmin <= temp_v; tmax <= temp_v;
			end else if (sample_valid) begin
				if (temp_v < tmin) tmin <= temp_v;
				if (temp_v > tmax) tmax <= temp_v;
			end
			if (hour_tick >= HOUR_CYC - 1) begin
				hour_tick <= 64'h0; hours <= hours + 32'h1;
			end else hour_tick <= hour_tick + 64'h1;
		end
	end

	wire [1:0] fb = ctrl[4:3];
	logic       fb_lvl;
	logic [7:0] fb_stat;
	always_comb begin
		fb_lvl = pre_level;
		fb_stat = pre_stat;
		if (!seen && !sim[1]) begin
			fb_stat = `ST_UNCERT_INI;
		end else if (pre_bad) begin
			case (fb)
				FS_SUBST: begin fb_lvl = safe[0]; fb_stat = `ST_SUBST; end
				FS_LAST: begin fb_lvl = last_good; fb_stat = `ST_LASTUSE; end
				default: begin fb_lvl = pre_level; fb_stat = pre_stat; end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_level <= 1'b0; out_status <= `ST_UNCERT_INI;
		end else if (sim[0]) begin
			out_level <= outman[0]; out_status <= outman[15:8];
		end else begin
			out_level <= fb_lvl ^ ctrl[2]; out_status <= fb_stat;
		end
	end

	// ------------------------------------------------------------------
	// sensor test
	// ------------------------------------------------------------------
	stest_e st;
	logic   st_pass;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= ST_IDLE; st_pass <= 1'b0;
		end else begin
			case (st)
				ST_IDLE: if (cmd_ok && pwdata[`CMD_STEST]) st <= ST_RUN;
				ST_RUN: begin st_pass <= stest_pass; st <= ST_DONE; end
				ST_DONE: if (cmd_ok && pwdata[`CMD_STEST]) st <= ST_RUN;
				default: st <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// display codes
	// ------------------------------------------------------------------
	wire key_dis = ~ctrl[1];
	wire [15:0] next_lock = hw_guard ? `DISP_L :
		(ctrl[0] & key_dis) ? `DISP_LL : ctrl[0] ? `DISP_LC :
		key_dis ? `DISP_LA : `DISP_NONE;
	wire [15:0] next_mode = (sim[4:0] != 5'h0) ? `DISP_SI : `DISP_NONE;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			disp_lock <= `DISP_NONE; disp_mode <= `DISP_NONE;
		end else begin
			disp_lock <= next_lock; disp_mode <= next_mode;
		end
	end

	// ------------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------------
	always_comb begin
		prdata = 32'h0;
		if (acc && !pwrite) begin
			case (paddr)
				`OFS_CTRL: prdata = ctrl;
				`OFS_CAL: prdata = cal;
				`OFS_SWPT: prdata = swpt;
				`OFS_SIM: prdata = sim;
				`OFS_SIMVAL: prdata = simval;
				`OFS_RAMP: prdata = ramp;
				`OFS_OUTMAN: prdata = outman;
				`OFS_STATUS: prdata = {8'h0, pct, out_status, st_pass, st == ST_DONE,
					comm_lost, warm_flag, cold_flag, hw_guard, sw_state, out_level};
				`OFS_SENSPK: prdata = {smax, smin};
				`OFS_TEMPPK: prdata = {tmax, tmin};
				`OFS_HOURS: prdata = hours;
				`OFS_ADDR: prdata = {25'h0, addr};
				`OFS_SAFE: prdata = safe;
				default: prdata = 32'h0;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	property p_addr_reset;
		@(posedge clk) disable iff (!rst_n)
			cmd_ok && pwdata[`CMD_ADDR] |=> station_addr == `ADDR_DEFAULT;
	endproperty
	a_addr_reset: assert property (p_addr_reset) else $error("address not default");
	property p_guard;
		// keypad enable bit moves with bus loss, not with writes
		@(posedge clk) disable iff (!rst_n)
			hw_guard && wr |=> $stable({ctrl[31:2], ctrl[0]}) || $past(key_ok);
	endproperty
	a_guard: assert property (p_guard) else $error("guarded write took effect");
	property p_peak;
		@(posedge clk) disable iff (!rst_n) cmd_ok && pwdata[`CMD_PK_SENS] |=> smin == smax;
	endproperty
	a_peak: assert property (p_peak) else $error("peak reset wrong");
	property p_hand;
		@(posedge clk) disable iff (!rst_n) sim[0] |=> out_level == $past(outman[0]);
	endproperty
	a_hand: assert property (p_hand) else $error("hand output wrong");
	property p_sim;
		@(posedge clk) disable iff (!rst_n) sim[3] |=> disp_mode == `DISP_SI;
	endproperty
	a_sim: assert property (p_sim) else $error("sim indicator missing");
	property p_lock;
		@(posedge clk) disable iff (!rst_n) hw_guard |=> disp_lock == `DISP_L;
	endproperty
	a_lock: assert property (p_lock) else $error("lock code wrong");
	property p_cold;
		@(posedge clk) disable iff (!rst_n) factory |=> disp_update_alert [*2];
	endproperty
	a_cold: assert property (p_cold) else $error("cold flag missing");
	property p_ramp;
		@(posedge clk) disable iff (!rst_n)
			sim[3] && $past(sim[3]) |-> ramp_val <= $past(ramp_val) + 16'h1;
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp jumped");
endmodule

`default_nettype wire

// ### hdl/level_switch_pkg.sv
package level_switch_pkg;
	typedef enum logic [1:0] {
		FS_SUBST = 2'h0,
		FS_LAST  = 2'h1,
		FS_PASS  = 2'h2
	} failsafe_e;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_RUN   = 3'b010,
		ST_DONE  = 3'b100
	} stest_e;
endpackage

// ### verif/fieldbus_master_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "level_switch_defines.svh"

module fieldbus_master_model (
	// clock
	input  wire logic        clk,
	// apb master side
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// ----------------------------------------------------------------
	// idle bus
	// ----------------------------------------------------------------
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end

	// setup cycle, then access held until pready is seen high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines must not keep the old value
		paddr <= ~paddr;
		pwdata <= ~pwdata;
	endtask

	task automatic join_default(input logic [6:0] na);
		logic [31:0] r;
		logic        e;
		xfer(1'b0, `OFS_ADDR, 32'h0, r, e);
		if (r[6:0] == `ADDR_DEFAULT && na < `ADDR_DEFAULT)
			xfer(1'b1, `OFS_ADDR, {25'h0, na}, r, e);
	endtask
endmodule
`default_nettype wire

// ### verif/level_switch_fault_sim_lock_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "level_switch_defines.svh"

module level_switch_fault_sim_lock_tb_top;
	import level_switch_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clk = 1'b0, rst_n = 1'b0, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        sample_valid, sensor_quality_bad, stest_pass;
	logic        bus_alive, key_edit_req, key_guard_toggle, rerr;
	logic [15:0] sensor_counts, elec_temp, disp_mode, disp_lock;
	logic [7:0]  sensor_status, out_status;
	logic        out_level, disp_update_alert, bus_drop;
	logic [6:0]  station_addr;
	int          n_fail = 0;
	int          num_checks = 0;
	int          cyc = 0;

	// short counts keep the run brief
	level_switch_fault_sim_lock #(.COLD_CYC(20), .WARM_CYC(10), .LOSS_CYC(50),
		.HOUR_CYC(100), .MS_CYC(2)) i_dut (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_valid(sample_valid), .sensor_counts(sensor_counts),
		.elec_temp(elec_temp), .sensor_quality_bad(sensor_quality_bad),
		.sensor_status(sensor_status), .stest_pass(stest_pass), .bus_alive(bus_alive),
		.key_edit_req(key_edit_req), .key_guard_toggle(key_guard_toggle),
		.out_level(out_level), .out_status(out_status), .disp_mode(disp_mode),
		.disp_lock(disp_lock), .disp_update_alert(disp_update_alert),
		.bus_drop(bus_drop), .station_addr(station_addr));
	fieldbus_master_model i_bus (.clk(clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	always #10 clk = ~clk;

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// a hang ends the run as a mismatch
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_bus.xfer(1'b1, a, d, rdat, rerr);
	endtask
	task automatic rd(input logic [11:0] a);
		i_bus.xfer(1'b0, a, 32'h0, rdat, rerr);
	endtask
	// one measurement; quality is bad when the top two status bits are zero
	task automatic smp(input logic [15:0] c, input logic [15:0] t, input logic [7:0] s);
		@(posedge clk);
		sample_valid <= 1'b1;
		sensor_counts <= c;
		elec_temp <= t;
		sensor_status <= s;
		sensor_quality_bad <= (s[7:6] == 2'b00);
		@(posedge clk);
		sample_valid <= 1'b0;
		tick(8);
	endtask
	// keypad pin pulse: guard toggle when sel is set, local edit otherwise
	task automatic pulse(input bit sel, input int n);
		if (sel)
			key_guard_toggle <= 1'b1;
		else
			key_edit_req <= 1'b1;
		tick(n);
		key_guard_toggle <= 1'b0;
		key_edit_req <= 1'b0;
		tick(6);
	endtask
	task automatic do_reset();
		rst_n <= 1'b0;
		tick(3);
		rst_n <= 1'b1;
		tick(1);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk("out_status", `ST_UNCERT_INI, out_status);
		chk("station_addr", `ADDR_DEFAULT, station_addr);
		chk("disp_lock", `DISP_NONE, disp_lock);
		rd(12'h0FC);
		chk("pslverr", 32'h1, rerr);
		$display("reset test done");
	endtask

	task automatic t_fall();
		logic [7:0] es [3] = '{`ST_SUBST, `ST_LASTUSE, 8'h1C};
		logic       el [3] = '{1'b0, 1'b1, 1'b0};
		wr(`OFS_CAL, 32'h03E8_0000);
		wr(`OFS_SAFE, 32'h0);
		wr(`OFS_CTRL, 32'h2);
		smp(16'd800, 16'd25, `ST_GOOD);
		chk("level", 32'h1, out_level);
		for (int m = 0; m < 3; m++) begin
			wr(`OFS_CTRL, 32'(m << 3) | 32'h2);
			smp(16'd100, 16'd25, 8'h1C);
			chk("fb level", el[m], out_level);
			chk("fb status", es[m], out_status);
		end
		$display("fallback test done");
	endtask

	task automatic t_switch();
		logic [15:0] c [5] = '{16'd600, 16'd450, 16'd300, 16'd450, 16'd510};
		logic        e [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
		wr(`OFS_CTRL, 32'h2);
		for (int i = 0; i < 5; i++) begin
			smp(c[i], 16'd25, `ST_GOOD);
			chk("switch", e[i], out_level);
		end
		smp(16'd300, 16'd25, `ST_GOOD);
		rd(`OFS_STATUS);
		chk("percent", 32'd30, rdat[23:16]);
		wr(`OFS_CTRL, 32'h6);
		smp(16'd300, 16'd25, `ST_GOOD);
		chk("inverted", 32'h1, out_level);
		$display("switch test done");
	endtask

	task automatic t_sim();
		wr(`OFS_CTRL, 32'h2);
		wr(`OFS_OUTMAN, 32'h0000_4B01);
		wr(`OFS_SIM, 32'h1);
		smp(16'd100, 16'd25, `ST_GOOD);
		chk("hand level", 32'h1, out_level);
		chk("hand status", `ST_SUBST, out_status);
		chk("disp_mode", `DISP_SI, disp_mode);
		wr(`OFS_CTRL, 32'h6);
		wr(`OFS_SIMVAL, 32'h8001_0000);
		wr(`OFS_SIM, 32'h2);
		smp(16'd100, 16'd25, `ST_GOOD);
		chk("insim level", 32'h0, out_level);
		wr(`OFS_SIMVAL, 32'h1001_0000);
		smp(16'd100, 16'd25, `ST_GOOD);
		chk("insim status", `ST_SUBST, out_status);
		wr(`OFS_SIM, 32'h0);
		wr(`OFS_CTRL, 32'h2);
		smp(16'd300, 16'd25, `ST_GOOD);
		chk("auto status", `ST_GOOD, out_status);
		chk("disp_mode", `DISP_NONE, disp_mode);
		$display("simulation test done");
	endtask

	task automatic t_peaks();
		smp(16'd500, 16'd40, `ST_GOOD);
		wr(`OFS_CMD, 32'h18);
		smp(16'd700, 16'd70, `ST_GOOD);
		smp(16'd200, 16'd20, `ST_GOOD);
		rd(`OFS_SENSPK);
		chk("sens peaks", {16'd700, 16'd200}, rdat);
		rd(`OFS_TEMPPK);
		chk("temp peaks", {16'd70, 16'd20}, rdat);
		wr(`OFS_CMD, 32'h18);
		rd(`OFS_SENSPK);
		chk("sens reset", {16'd200, 16'd200}, rdat);
		rd(`OFS_TEMPPK);
		chk("temp reset", {16'd20, 16'd20}, rdat);
		$display("peak test done");
	endtask

	// fixed value 10 for sensor and temperature, then a 10..12 ramp, 1 ms dwell
	task automatic t_ramp();
		wr(`OFS_SIMVAL, 32'h0000_000A);
		wr(`OFS_RAMP, 32'h0001_000C);
		wr(`OFS_SIM, 32'h14);
		smp(16'd500, 16'd40, `ST_GOOD);
		wr(`OFS_CMD, 32'h18);
		smp(16'd500, 16'd40, `ST_GOOD);
		rd(`OFS_SENSPK);
		chk("fixed peaks", {16'd10, 16'd10}, rdat);
		wr(`OFS_SIM, 32'h18);
		wr(`OFS_CMD, 32'h18);
		// nine samples ten cycles apart cover every step of the 18-cycle ramp period
		repeat (9) smp(16'd500, 16'd40, `ST_GOOD);
		chk("ramp mode", `DISP_SI, disp_mode);
		rd(`OFS_SENSPK);
		chk("ramp peaks", {16'd12, 16'd10}, rdat);
		rd(`OFS_TEMPPK);
		chk("temp sim peaks", {16'd10, 16'd10}, rdat);
		wr(`OFS_SIM, 32'h0);
		$display("ramp test done");
	endtask

	task automatic t_cmds();
		wr(`OFS_ADDR, 32'h5);
		wr(`OFS_CMD, 32'h4);
		tick(2);
		chk("addr reset", `ADDR_DEFAULT, station_addr);
		i_bus.join_default(7'd125);
		tick(2);
		chk("addr join", 32'd125, station_addr);
		wr(`OFS_SWPT, 32'h1E3C);
		wr(`OFS_CMD, 32'h1);
		rd(`OFS_STATUS);
		chk("cold flag", 32'h1, rdat[3]);
		chk("alert", 32'h1, disp_update_alert);
		tick(30);
		chk("alert off", 32'h0, disp_update_alert);
		rd(`OFS_SWPT);
		chk("defaults", 32'h2832, rdat);
		wr(`OFS_CMD, 32'h2);
		rd(`OFS_STATUS);
		chk("warm flag", 32'h1, rdat[4]);
		chk("bus_drop", 32'h1, bus_drop);
		chk("warm status", `ST_UNCERT_INI, rdat[15:8]);
		tick(20);
		rd(`OFS_STATUS);
		chk("warm off", 32'h0, rdat[4]);
		chk("bus_drop off", 32'h0, bus_drop);
		for (int p = 1; p >= 0; p--) begin
			stest_pass <= p[0];
			wr(`OFS_CMD, 32'h20);
			tick(20);
			rd(`OFS_STATUS);
			chk("sensor test", {p[0], 1'b1}, rdat[7:6]);
		end
		$display("command test done");
	endtask

	task automatic t_locks();
		pulse(1'b1, 6);
		chk("guard code", `DISP_L, disp_lock);
		wr(`OFS_CTRL, 32'h6);
		chk("guard refuse", 32'h1, rerr);
		rd(`OFS_CTRL);
		chk("ctrl kept", 32'h2, rdat);
		pulse(1'b1, 6);
		wr(`OFS_CTRL, 32'h3);
		tick(4);
		chk("buslock code", `DISP_LC, disp_lock);
		wr(`OFS_CAL, 32'h0);
		chk("buslock refuse", 32'h1, rerr);
		do_reset();
		wr(`OFS_CTRL, 32'h1);
		tick(4);
		chk("both code", `DISP_LL, disp_lock);
		pulse(1'b0, 1);
		rd(`OFS_CTRL);
		chk("keypad off", 32'h0, rdat[2]);
		bus_alive <= 1'b0;
		tick(60);
		rd(`OFS_STATUS);
		chk("comm lost", 32'h1, rdat[5]);
		pulse(1'b0, 1);
		rd(`OFS_CTRL);
		chk("keypad auto", 32'h1, rdat[2]);
		chk("keypad forced", 32'h1, rdat[1]);
		bus_alive <= 1'b1;
		tick(8);
		rd(`OFS_CTRL);
		chk("keypad back", 32'h0, rdat[1]);
		$display("lock test done");
	endtask

	task automatic t_hours();
		logic [31:0] h0;
		rd(`OFS_HOURS);
		h0 = rdat;
		// 197 idle edges and the three edges of a read span 200 cycles, two hours of 100
		tick(197);
		rd(`OFS_HOURS);
		chk("hours", h0 + 32'd2, rdat);
		$display("hours test done");
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		sample_valid <= 1'b0;
		sensor_quality_bad <= 1'b0;
		stest_pass <= 1'b0;
		bus_alive <= 1'b1;
		key_edit_req <= 1'b0;
		key_guard_toggle <= 1'b0;
		sensor_counts <= 16'h0;
		elec_temp <= 16'h0;
		sensor_status <= `ST_GOOD;
		do_reset();
		t_reset();
		t_fall();
		t_switch();
		t_sim();
		t_peaks();
		t_ramp();
		t_cmds();
		t_locks();
		t_hours();
		give_verdict();
	end
endmodule
`default_nettype wire
